/* rtl/gcc_defs.svh */
// Register offsets, field positions, reset values and loop bounds.
`ifndef GCC_DEFS_SVH
`define GCC_DEFS_SVH

// =====================================================================
// Register map
`define GCC_GAIN_ADDR 5'h0B
`define GCC_STAT_ADDR 5'h0C
`define GCC_MAP_FIRST 5'h00
`define GCC_MAP_LAST 5'h1F
`define GCC_WR_FIRST 5'h08
`define GCC_GROUP_MASK 5'h03
`define GCC_TYPE_MASK 5'h07

// =====================================================================
// Gain register layout
`define GCC_NUM_CH 3
`define GCC_CODE_W 3
`define GCC_GAIN_W 9
`define GCC_GAIN_RST 9'h000
`define GCC_GAIN_PAD 15'h0000

// =====================================================================
// Status and communication register layout
// The stored configuration word holds bits 23:12 of the register.
`define GCC_CFG_LSB 12
`define GCC_CFG_RST 12'hA90
`define GCC_FLAGS_RST 3'h7
`define GCC_STAT_PAD 9'h000
`define GCC_RD_HI 11
`define GCC_RD_LO 10
`define GCC_WR_INC 9
`define GCC_IDLE_FLOAT 8
`define GCC_LINK 7
`define GCC_WCRC 6
`define GCC_WDATA_HI 5
`define GCC_WDATA_LO 4
`define GCC_CRC_EN 3
`define GCC_INT_EN 2

`endif

/* rtl/gcc_pkg.sv */
// Types shared by the gain and communication configuration block.
package gcc_pkg;

	// Read address increment modes, in field code order 00 to 11.
	typedef enum logic [1:0] {
		GCC_RD_SAME,
		GCC_RD_GROUP,
		GCC_RD_TYPE,
		GCC_RD_ALL
	} gcc_rd_mode_t;

	// Whole state of the register bank.
	typedef struct packed {
		logic [8:0] gain;
		logic [11:0] cfg;
		logic [2:0] flags;
		logic [4:0] addr;
		logic [23:0] rdata;
		logic rvalid;
		logic [8:0] shift;
		logic pin_out;
		logic pin_oe;
	} gcc_state_t;

endpackage

/* rtl/gcc_gain_if.sv */
// Gain codes out to the decoder and decoded gain shifts back.
`timescale 1ns/1ps
interface gcc_gain_if;
	logic [8:0] code;
	logic [8:0] shift;
	modport ctrl (output code, input shift);
	modport dec (input code, output shift);
endinterface

/* rtl/gcc_gain_decode.sv */
// Per-channel amplifier gain decoder: code to power-of-two shift.
`timescale 1ns/1ps
`include "gcc_defs.svh"
module gcc_gain_decode import gcc_pkg::*; #(
	parameter int NUM_CH = `GCC_NUM_CH
) (
	// Codes in, shifts out
	gcc_gain_if.dec gif
);

	// =================================================================
	// Elaboration check
	// The gain register only has room for three 3-bit codes.
	generate
		if (NUM_CH < 1 || NUM_CH > `GCC_NUM_CH) begin : g_bad
			$error("gcc_gain_decode: NUM_CH must be 1 to 3");
		end
	endgenerate

	// =================================================================
	// Decoding
	// Shift n means gain 2**n; reserved codes fall back to unity gain.
	function automatic logic [2:0] gcc_shift(input logic [2:0] code);
		logic [2:0] s;
		s = 3'h0;
		unique case (code)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: s = code;
			3'h6, 3'h7: s = 3'h0;
		endcase
		return s;
	endfunction

	// One decoder per channel; unused channel slots read unity.
	genvar ch;
	generate
		for (ch = 0; ch < `GCC_NUM_CH; ch++) begin : g_ch
			if (ch < NUM_CH) begin : g_on
				assign gif.shift[ch*3 +: 3] = gcc_shift(gif.code[ch*3 +: 3]);
			end else begin : g_off
				assign gif.shift[ch*3 +: 3] = 3'h0;
			end
		end
	endgenerate

endmodule

/* rtl/gcc_regs.sv */
// Gain and status/communication configuration register bank.
`timescale 1ns/1ps
`include "gcc_defs.svh"
// How it works
// - Gain register low nine bits hold three 3-bit channel gain codes.
// - Gain codes 000 to 101 select gains 1, 2, 4, 8, 16, 32.
// - Gain codes 110 and 111 are reserved and give unity gain.
// - After reset every channel gain code is 000, unity gain.
// - Gain register bits 23 to 9 always read as zero.
// - Status register at 0x0C; bits 11:3 read zero, 2:0 read-only flags.
// - Idle-float bit 1 drives ready pin high when idle; 0 floats it.
// - Write increment bit loops writes over the writable map, else stays.
// - Read increment field: whole map, types, groups, or same address.
module gcc_regs import gcc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register access port
	input wire logic cmd_start,
	input wire logic [4:0] cmd_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	output logic reg_rvalid,
	output logic [4:0] reg_addr_ptr,
	// Converter side
	input wire logic data_ready,
	input wire logic [2:0] ready_flags_in,
	// Ready pin, active low, three-state
	output logic ready_pin_n_out,
	output logic ready_pin_n_oe,
	// Configuration outputs
	output logic [8:0] channel_gain_code,
	output logic [8:0] gain_shift,
	output logic [1:0] read_inc_mode,
	output logic write_inc,
	output logic ready_link_select,
	output logic width_crc,
	output logic [1:0] width_data,
	output logic comm_checksum_enable,
	output logic config_int_enable
);

	// =================================================================
	// State and gain decoder
	gcc_state_t st;
	gcc_state_t next_st;
	logic [4:0] acc;
	gcc_gain_if gif ();

	assign gif.code = st.gain;

	gcc_gain_decode #(
		.NUM_CH(`GCC_NUM_CH)
	) u_dec (
		.gif(gif.dec)
	);

	// =================================================================
	// Address stepping
	// Step within [lo, hi], wrapping back to lo after hi.
	function automatic logic [4:0] gcc_wrap(input logic [4:0] a,
		input logic [4:0] lo, input logic [4:0] hi);
		return (a == hi) ? lo : 5'(a + 5'h01);
	endfunction

	// Next address after a read, by the read increment mode.
	function automatic logic [4:0] gcc_rd_step(input logic [4:0] a,
		input gcc_rd_mode_t m);
		logic [4:0] n;
		n = a;
		unique case (m)
			GCC_RD_SAME: n = a;
			GCC_RD_GROUP: n = gcc_wrap(a, a & ~`GCC_GROUP_MASK,
				a | `GCC_GROUP_MASK);
			GCC_RD_TYPE: n = gcc_wrap(a, a & ~`GCC_TYPE_MASK,
				a | `GCC_TYPE_MASK);
			GCC_RD_ALL: n = gcc_wrap(a, `GCC_MAP_FIRST, `GCC_MAP_LAST);
		endcase
		return n;
	endfunction

	// Read word of one address; unmapped addresses read zero.
	function automatic logic [23:0] gcc_word(input logic [4:0] a,
		input gcc_state_t s);
		logic [23:0] w;
		w = 24'h000000;
		if (a == `GCC_GAIN_ADDR) begin
			w = {`GCC_GAIN_PAD, s.gain};
		end else if (a == `GCC_STAT_ADDR) begin
			w = {s.cfg, `GCC_STAT_PAD, s.flags};
		end
		return w;
	endfunction

	// =================================================================
	// Next state
	// A write and a read in one cycle: the write is taken, the read is
	// dropped, so the address pointer never steps twice.
	always_comb begin
		next_st = st;
		acc = cmd_start ? cmd_addr : st.addr;
		next_st.flags = ready_flags_in;
		next_st.rvalid = 1'b0;
		next_st.shift = gif.shift;
		if (reg_write) begin
			if (acc == `GCC_GAIN_ADDR) begin
				next_st.gain = reg_wdata[8:0];
			end else if (acc == `GCC_STAT_ADDR) begin
				next_st.cfg = reg_wdata[23:`GCC_CFG_LSB];
			end
			if (st.cfg[`GCC_WR_INC]) begin
				next_st.addr = gcc_wrap(acc, `GCC_WR_FIRST,
					`GCC_MAP_LAST);
			end else begin
				next_st.addr = acc;
			end
		end else if (reg_read) begin
			next_st.rdata = gcc_word(acc, st);
			next_st.rvalid = 1'b1;
			next_st.addr = gcc_rd_step(acc,
				gcc_rd_mode_t'(st.cfg[`GCC_RD_HI:`GCC_RD_LO]));
		end else if (cmd_start) begin
			next_st.addr = cmd_addr;
		end
		// Pin is low while data is ready; idle is high or floating.
		if (data_ready) begin
			next_st.pin_out = 1'b0;
			next_st.pin_oe = 1'b1;
		end else begin
			next_st.pin_out = 1'b1;
			next_st.pin_oe = st.cfg[`GCC_IDLE_FLOAT];
		end
	end

	// =================================================================
	// State register
	// The pin floats in reset so it never fights a shared line.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st.gain <= `GCC_GAIN_RST;
			st.cfg <= `GCC_CFG_RST;
			st.flags <= `GCC_FLAGS_RST;
			st.addr <= `GCC_MAP_FIRST;
			st.rdata <= 24'h000000;
			st.rvalid <= 1'b0;
			st.shift <= 9'h000;
			st.pin_out <= 1'b1;
			st.pin_oe <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// =================================================================
	// Outputs
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign reg_addr_ptr = st.addr;
	assign ready_pin_n_out = st.pin_out;
	assign ready_pin_n_oe = st.pin_oe;
	assign channel_gain_code = st.gain;
	assign gain_shift = st.shift;
	assign read_inc_mode = st.cfg[`GCC_RD_HI:`GCC_RD_LO];
	assign write_inc = st.cfg[`GCC_WR_INC];
	assign ready_link_select = st.cfg[`GCC_LINK];
	assign width_crc = st.cfg[`GCC_WCRC];
	assign width_data = st.cfg[`GCC_WDATA_HI:`GCC_WDATA_LO];
	assign comm_checksum_enable = st.cfg[`GCC_CRC_EN];
	assign config_int_enable = st.cfg[`GCC_INT_EN];

	// =================================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_gain_wr;
		reg_write && acc == `GCC_GAIN_ADDR;
	endsequence

	sequence s_stat_rd;
		reg_read && !reg_write && acc == `GCC_STAT_ADDR;
	endsequence

	sequence s_idle_float;
		!data_ready && st.cfg[`GCC_IDLE_FLOAT];
	endsequence

	chk_gain_layout: assert property (
		s_gain_wr |=> channel_gain_code[5:3] == $past(reg_wdata[5:3])
	) else $error("channel 1 gain code not taken from bits 5:3");

	chk_gain_decode: assert property (
		s_gain_wr and reg_wdata[8:6] == 3'h5 |-> ##2 gain_shift[8:6] == 3'h5
	) else $error("code 101 does not give gain 32");

	chk_gain_reserved: assert property (
		s_gain_wr and reg_wdata[2:1] == 2'h3 |-> ##2 gain_shift[2:0] == 3'h0
	) else $error("reserved gain code not unity");

	chk_gain_readzero: assert property (
		reg_read && !reg_write && acc == `GCC_GAIN_ADDR
		|=> reg_rvalid && reg_rdata[23:9] == 15'h0000
	) else $error("gain register upper bits not zero");

	chk_status_read: assert property (
		s_stat_rd |=> reg_rvalid && reg_rdata[11:3] == 9'h000
			&& reg_rdata[2:0] == $past(st.flags)
	) else $error("status read has wrong low bits");

	chk_idle_float: assert property (
		s_idle_float |=> ready_pin_n_oe && ready_pin_n_out
	) else $error("ready pin not driven high while idle");

	chk_idle_hiz: assert property (
		!data_ready && !st.cfg[`GCC_IDLE_FLOAT] |=> !ready_pin_n_oe
	) else $error("ready pin driven while idle float is off");

	chk_write_hold: assert property (
		reg_write && !write_inc |=> reg_addr_ptr == $past(acc)
	) else $error("write address moved with increment off");

	chk_write_wrap: assert property (
		reg_write && write_inc && acc == `GCC_MAP_LAST
		|=> reg_addr_ptr == `GCC_WR_FIRST
	) else $error("write address did not loop to writable start");

	chk_read_group: assert property (
		reg_read && !reg_write && read_inc_mode == 2'h1
		&& acc[1:0] == 2'h3 |=> reg_addr_ptr == {$past(acc[4:2]), 2'h0}
	) else $error("group read did not loop");

	chk_unimpl_drop: assert property (
		reg_write && acc == `GCC_STAT_ADDR
		##1 reg_read && !reg_write && acc == `GCC_STAT_ADDR
		|=> reg_rdata[11:3] == 9'h000
			&& reg_rdata[23:12] == $past(reg_wdata[23:12], 2)
	) else $error("unimplemented status bits kept write data");

endmodule

/* tb/gcc_regs_test.sv */
// Self-checking testbench for the gain and status register bank.
`timescale 1ns/1ps
module gcc_regs_test import gcc_pkg::*; ;
	// ==============================================================
	// Signals
	logic clock, rst_n, cmd_start, reg_write, reg_read, data_ready;
	logic [4:0] cmd_addr, reg_addr_ptr;
	logic [23:0] reg_wdata, reg_rdata, q, d;
	logic [2:0] ready_flags_in;
	logic reg_rvalid, ready_pin_n_out, ready_pin_n_oe, write_inc;
	logic [8:0] channel_gain_code, gain_shift;
	logic [1:0] read_inc_mode, width_data;
	logic ready_link_select, width_crc;
	logic comm_checksum_enable, config_int_enable;
	logic [31:0] seed = 32'h00000043;
	logic [4:0] a;
	int error_cnt = 0;
	int checks_done = 0;

	gcc_regs gcc_regs_inst (.clock(clock), .rst_n(rst_n),
		.cmd_start(cmd_start), .cmd_addr(cmd_addr),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_addr_ptr(reg_addr_ptr),
		.data_ready(data_ready), .ready_flags_in(ready_flags_in),
		.ready_pin_n_out(ready_pin_n_out),
		.ready_pin_n_oe(ready_pin_n_oe),
		.channel_gain_code(channel_gain_code), .gain_shift(gain_shift),
		.read_inc_mode(read_inc_mode), .write_inc(write_inc),
		.ready_link_select(ready_link_select), .width_crc(width_crc),
		.width_data(width_data),
		.comm_checksum_enable(comm_checksum_enable),
		.config_int_enable(config_int_enable));

	// ==============================================================
	// Helpers
	// Free-running clock at 25 MHz.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Xorshift generator so every run sees the same stimulus.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Reserved codes fall back to unity gain, which is a zero shift.
	function automatic logic [8:0] exp_shift(input logic [8:0] c);
		logic [8:0] s;
		for (int i = 0; i < 3; i++) begin
			s[i*3 +: 3] = (c[i*3 +: 3] < 3'h6) ? c[i*3 +: 3] : 3'h0;
		end
		return s;
	endfunction

	// Pointer after a read, stepping inside the block the mode names.
	function automatic logic [4:0] nptr(input logic [4:0] p,
			input logic [1:0] m);
		case (m)
			2'b11: return p + 5'h01;
			2'b10: return {p[4:3], p[2:0] + 3'h1};
			2'b01: return {p[4:2], p[1:0] + 2'h1};
			default: return p;
		endcase
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access held for a single taking edge, released just after it.
	task automatic acc(input logic st, input logic [4:0] ad,
			input logic wr, input logic rd_en, input logic [23:0] wd);
		@(posedge clock);
		#1;
		cmd_start = st;
		cmd_addr = ad;
		reg_write = wr;
		reg_read = rd_en;
		reg_wdata = wd;
		@(posedge clock);
		#1;
		cmd_start = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
	endtask

	// The read pulse lasts one cycle, so it is sampled right here.
	task automatic rd(input logic st, input logic [4:0] ad);
		acc(st, ad, 1'b0, 1'b1, 24'h000000);
		chk(reg_rvalid, 24'h000001);
		q = reg_rdata;
	endtask

	// Write, then read the same address on the very next edge.
	task automatic wr_rd(input logic [4:0] ad, input logic [23:0] wd);
		@(posedge clock);
		#1;
		{cmd_start, reg_write, reg_read} = 3'b110;
		cmd_addr = ad;
		reg_wdata = wd;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
		reg_read = 1'b1;
		@(posedge clock);
		#1;
		{cmd_start, reg_read} = 2'b00;
		chk(reg_rvalid, 24'h000001);
		q = reg_rdata;
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the 160 or so cycles the tests need.
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		print_verdict();
	end

	// ==============================================================
	// Tests
	initial begin
		{cmd_start, reg_write, reg_read, data_ready} = 4'h0;
		cmd_addr = 5'h00;
		reg_wdata = 24'h000000;
		ready_flags_in = 3'h5;
		rst_n = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(channel_gain_code, 24'h000000);
		rd(1'b1, 5'h0C);
		chk(q, 24'hA90005);
		rd(1'b1, 5'h0B);
		chk(q, 24'h000000);
		$display("test reset done");
		// Every code on every channel, padded with random upper bits.
		for (int i = 0; i < 16; i++) begin
			d = 24'(rnd());
			if (i < 8) d[8:0] = {3'(i), 3'(7 - i), 3'(i)};
			acc(1'b1, 5'h0B, 1'b1, 1'b0, d);
			chk(reg_addr_ptr, 24'h00000C);
			@(posedge clock);
			#1;
			chk(channel_gain_code, d[8:0]);
			chk(gain_shift, exp_shift(d[8:0]));
			rd(1'b1, 5'h0B);
			chk(q, {15'h0000, d[8:0]});
		end
		$display("test gain done");
		for (int i = 0; i < 8; i++) begin
			d = 24'(rnd());
			ready_flags_in = d[2:0] ^ 3'h6;
			// Back-to-back write and read-back of the status word.
			wr_rd(5'h0C, d);
			chk({read_inc_mode, write_inc, ready_link_select, width_crc,
				width_data, comm_checksum_enable, config_int_enable},
				{d[23:21], d[19:14]});
			chk(q, {d[23:12], 9'h000, d[2:0] ^ 3'h6});
		end
		$display("test status done");
		// Ready pin with the idle-float bit off then on.
		for (int f = 0; f < 2; f++) begin
			acc(1'b1, 5'h0C, 1'b1, 1'b0, {3'h5, 1'(f), 8'h90, 12'h000});
			data_ready = 1'b1;
			@(posedge clock);
			#1;
			chk({ready_pin_n_out, ready_pin_n_oe}, 24'h000001);
			data_ready = 1'b0;
			@(posedge clock);
			#1;
			chk({ready_pin_n_out, ready_pin_n_oe}, {1'b1, 1'(f)});
		end
		$display("test pin done");
		// Read stepping in all four modes from random start points.
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, 5'h0C, 1'b1, 1'b0, {2'(m), 10'h290, 12'h000});
			a = 5'(rnd());
			// Group mode starts at a group's last address to force a wrap.
			if (m == 1) a[1:0] = 2'h3;
			rd(1'b1, a);
			a = nptr(a, 2'(m));
			chk(reg_addr_ptr, a);
			rd(1'b0, 5'h00);
			chk(reg_addr_ptr, nptr(a, 2'(m)));
		end
		// Write stepping: wrap at the top, then hold in place.
		acc(1'b1, 5'h0C, 1'b1, 1'b0, 24'hA90000);
		acc(1'b1, 5'h1F, 1'b1, 1'b0, 24'h000007);
		chk(reg_addr_ptr, 24'h000008);
		acc(1'b1, 5'h0C, 1'b1, 1'b0, 24'h890000);
		acc(1'b1, 5'h0B, 1'b1, 1'b0, 24'h000007);
		chk(reg_addr_ptr, 24'h00000B);
		acc(1'b0, 5'h00, 1'b1, 1'b0, 24'h000024);
		chk(reg_addr_ptr, 24'h00000B);
		chk(channel_gain_code, 24'h000024);
		$display("test pointer done");
		// A second reset in mid-run brings unity gain and defaults back.
		@(posedge clock);
		#1;
		rst_n = 1'b0;
		@(posedge clock);
		#1;
		chk({channel_gain_code, gain_shift}, 24'h000000);
		rst_n = 1'b1;
		rd(1'b1, 5'h0C);
		chk(q, {12'hA90, 9'h000, ready_flags_in});
		rd(1'b1, 5'h0B);
		chk(q, 24'h000000);
		$display("test reset again done");
		print_verdict();
	end
endmodule
